/* core/led_latch_defs.vh */
// constants for the led driver serial load and latch port
// assumes inclusion by bare name from the design files
`ifndef LED_LATCH_DEFS_VH
`define LED_LATCH_DEFS_VH
`define CHANNELS      16
`define CORR_BITS     7
`define ONOFF_LEN     16
`define CORR_LEN      112
`define ONOFF_RST     16'h0000
`define CORR_RST      112'h0
`define BUF_DEPTH     2
`define CORR_FIELD_RST 7'h00
`define PIN_RST       1'b0
`endif

/* core/bit_buffer.v */
// two-entry buffer with valid and ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module bit_buffer (
  clk,
  rst,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire       clk;
  input  wire       rst;
  input  wire       in_valid;
  output wire       in_ready;
  input  wire [1:0] in_data;
  output wire       out_valid;
  input  wire       out_ready;
  output wire [1:0] out_data;

  reg [1:0] mem_r [0:1];
  reg       wr_ptr_r;
  reg       rd_ptr_r;
  reg [1:0] count_r;
  wire      push;
  wire      pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
      mem_r[0] <= 2'h0;
      mem_r[1] <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push)
        count_r <= count_r - 2'h1;
    end
  end
endmodule // bit_buffer

/* core/led_serial_latch.v */
// serial load and latch logic of a 16-channel led sink driver
// assumes all pins are asynchronous to clk, which runs far faster than the shift clock
`timescale 1ns/100ps
`include "led_latch_defs.vh"
module led_serial_latch (
  clk,
  rst,
  shift_clk,
  serial_data_in,
  mode_sel,
  latch_strobe,
  blank,
  open_led_detect,
  overtemp_flag,
  serial_data_out,
  error_out_n_o,
  error_out_n_oe,
  chan_on,
  onoff_data,
  brightness_correction
);
  input  wire                       clk;
  input  wire                       rst;
  input  wire                       shift_clk;
  input  wire                       serial_data_in;
  input  wire                       mode_sel;
  input  wire                       latch_strobe;
  input  wire                       blank;
  input  wire [`CHANNELS-1:0]       open_led_detect;
  input  wire                       overtemp_flag;
  output reg                        serial_data_out;
  output wire                       error_out_n_o;
  output wire                       error_out_n_oe;
  output reg  [`CHANNELS-1:0]       chan_on;
  output wire [`CHANNELS-1:0]       onoff_data;
  output wire [`CORR_LEN-1:0]       brightness_correction;

  // pin synchronisers: one two-stage chain per pin bit
  localparam PIN_W = `CHANNELS + 6;

  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_sync;

  assign pin_raw = {overtemp_flag,
                    open_led_detect,
                    blank,
                    latch_strobe,
                    mode_sel,
                    serial_data_in,
                    shift_clk};

  genvar p;
  generate
    for (p = 0; p < PIN_W; p = p + 1) begin : g_sync
      reg stage1_r;
      reg stage2_r;

      always @(posedge clk) begin
        if (rst) begin
          stage1_r <= `PIN_RST;
          stage2_r <= `PIN_RST;
        end else begin
          stage1_r <= pin_raw[p];
          stage2_r <= stage1_r;
        end
      end

      assign pin_sync[p] = stage2_r;
    end
  endgenerate

  // synchronised pin levels
  wire                 sck_s;
  wire                 sdi_s;
  wire                 mode_s;
  wire                 lat_s;
  wire                 blk_s;
  wire [`CHANNELS-1:0] open_s;
  wire                 hot_s;

  assign sck_s  = pin_sync[0];
  assign sdi_s  = pin_sync[1];
  assign mode_s = pin_sync[2];
  assign lat_s  = pin_sync[3];
  assign blk_s  = pin_sync[4];
  assign open_s = pin_sync[`CHANNELS+4:5];
  assign hot_s  = pin_sync[`CHANNELS+5];

  // edge detectors rest low, the idle level of both pins
  reg  sck_d_r;
  reg  lat_d_r;
  wire sck_rise;
  wire lat_rise;

  assign sck_rise = sck_s & ~sck_d_r;
  assign lat_rise = lat_s & ~lat_d_r;

  // each shifted bit is held, then queued with the mode it arrived in
  reg        hold_r;
  reg        hold_nxt;
  reg        hold_mode_r;
  reg        hold_mode_nxt;
  reg        hold_bit_r;
  reg        hold_bit_nxt;
  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [1:0] buf_out_data;
  wire       corr_load;
  wire       apply_ready;
  wire       apply;

  // a transparent correction latch stalls the queue so no bit slips past it
  assign corr_load   = lat_s & mode_s;
  assign apply_ready = ~corr_load;
  assign apply       = buf_out_valid & apply_ready;

  always @* begin
    hold_nxt      = hold_r;
    hold_mode_nxt = hold_mode_r;
    hold_bit_nxt  = hold_bit_r;
    if (sck_rise) begin
      hold_nxt      = 1'b1;
      hold_mode_nxt = mode_s;
      hold_bit_nxt  = sdi_s;
    end else if (buf_in_ready) begin
      hold_nxt = 1'b0;
    end
  end

  bit_buffer u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (hold_r),
    .in_ready  (buf_in_ready),
    .in_data   ({hold_mode_r, hold_bit_r}),
    .out_valid (buf_out_valid),
    .out_ready (apply_ready),
    .out_data  (buf_out_data)
  );

  // input shift registers and the on/off register
  reg  [`ONOFF_LEN-1:0] onoff_sr_r;
  reg  [`ONOFF_LEN-1:0] onoff_sr_nxt;
  reg  [`CORR_LEN-1:0]  corr_sr_r;
  reg  [`CORR_LEN-1:0]  corr_sr_nxt;
  reg  [`ONOFF_LEN-1:0] onoff_reg_r;
  reg  [`ONOFF_LEN-1:0] onoff_reg_nxt;
  wire [`CORR_LEN-1:0]  corr_reg;
  wire [`CHANNELS-1:0]  chan_gated;

  always @* begin
    onoff_sr_nxt = onoff_sr_r;
    corr_sr_nxt  = corr_sr_r;
    if (apply) begin
      if (buf_out_data[1])
        corr_sr_nxt = {corr_sr_r[`CORR_LEN-2:0], buf_out_data[0]};
      else
        onoff_sr_nxt = {onoff_sr_r[`ONOFF_LEN-2:0], buf_out_data[0]};
    end
  end

  always @* begin
    onoff_reg_nxt = onoff_reg_r;
    if (lat_rise && !mode_s)
      onoff_reg_nxt = onoff_sr_r;
  end

  // per channel: correction field latch and blanking gate
  genvar c;
  generate
    for (c = 0; c < `CHANNELS; c = c + 1) begin : g_chan
      reg [`CORR_BITS-1:0] field_r;

      always @(posedge clk) begin
        if (rst)
          field_r <= `CORR_FIELD_RST;
        else if (corr_load)
          field_r <= corr_sr_r[c*`CORR_BITS +: `CORR_BITS];
      end

      // latch low: the field keeps its value
      assign corr_reg[c*`CORR_BITS +: `CORR_BITS] = field_r;
      assign chan_gated[c] = onoff_reg_r[c] & ~blk_s;
    end
  endgenerate

  // serial output, error pin and the clocked state
  wire err_any;
  reg  err_r;
  reg  serial_data_out_nxt;

  assign err_any = (|open_s) | hot_s;

  always @* begin
    if (mode_s)
      serial_data_out_nxt = corr_sr_r[`CORR_LEN-1];
    else
      serial_data_out_nxt = onoff_sr_r[`ONOFF_LEN-1];
  end

  always @(posedge clk) begin
    if (rst) begin
      sck_d_r         <= 1'b0;
      lat_d_r         <= 1'b0;
      hold_r          <= 1'b0;
      hold_mode_r     <= 1'b0;
      hold_bit_r      <= 1'b0;
      onoff_sr_r      <= `ONOFF_RST;
      corr_sr_r       <= `CORR_RST;
      onoff_reg_r     <= `ONOFF_RST;
      chan_on         <= `ONOFF_RST;
      serial_data_out <= 1'b0;
      err_r           <= 1'b0;
    end else begin
      sck_d_r         <= sck_s;
      lat_d_r         <= lat_s;
      hold_r          <= hold_nxt;
      hold_mode_r     <= hold_mode_nxt;
      hold_bit_r      <= hold_bit_nxt;
      onoff_sr_r      <= onoff_sr_nxt;
      corr_sr_r       <= corr_sr_nxt;
      onoff_reg_r     <= onoff_reg_nxt;
      chan_on         <= chan_gated;
      serial_data_out <= serial_data_out_nxt;
      err_r           <= err_any;
    end
  end

  assign onoff_data            = onoff_reg_r;
  assign brightness_correction = corr_reg;
  assign error_out_n_o         = 1'b0;
  assign error_out_n_oe        = err_r;
endmodule // led_serial_latch

/* bench/led_serial_latch_properties.sv */
// checks on the led serial latch port
// assumes a bind to led_serial_latch, inputs named as its ports
`timescale 1ns/100ps
module led_serial_latch_properties (
  input wire clk, rst, shift_clk, mode_sel, latch_strobe, blank, overtemp_flag,
  input wire serial_data_out, error_out_n_oe,
  input wire [15:0] open_led_detect, chan_on, onoff_data,
  input wire [111:0] brightness_correction
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_eon; (overtemp_flag || |open_led_detect)[*4] |=> error_out_n_oe; endproperty
  a_eon: assert property (p_eon) else $error("err not set");
  property p_eoff; !(overtemp_flag || |open_led_detect)[*4] |=> !error_out_n_oe; endproperty
  a_eoff: assert property (p_eoff) else $error("err not clear");
  property p_blank; blank[*4] |=> chan_on == 16'h0000; endproperty
  a_blank: assert property (p_blank) else $error("blank");
  property p_ohold; !latch_strobe[*6] |=> $stable(onoff_data); endproperty
  a_ohold: assert property (p_ohold) else $error("onoff moved");
  property p_chold; !latch_strobe[*6] |=> $stable(brightness_correction); endproperty
  a_chold: assert property (p_chold) else $error("corr moved");
  property p_mlow; !mode_sel[*6] |=> $stable(brightness_correction); endproperty
  a_mlow: assert property (p_mlow) else $error("corr in mode low");
  property p_mhigh; mode_sel[*6] |=> $stable(onoff_data); endproperty
  a_mhigh: assert property (p_mhigh) else $error("onoff in mode high");
  property p_serial_data_out; (!shift_clk && $stable(mode_sel))[*8] |=> $stable(serial_data_out); endproperty
  a_serial_data_out: assert property (p_serial_data_out) else $error("serial_data_out moved");
  c_onoff: cover property (!mode_sel && $rose(latch_strobe));
  c_corr: cover property (mode_sel && latch_strobe);
  c_err: cover property ($rose(error_out_n_oe));
endmodule // led_serial_latch_properties

/* bench/led_host_model.sv */
// host that shifts words into the port, 80 ns shift clock
// assumes the bench calls send; shift clock rests low between frames
`timescale 1ns/100ps
module led_host_model (
  input  wire clk,
  output reg  shift_clk,
  output reg  serial_data_in
);
  initial begin
    shift_clk = 0;
    serial_data_in = 0;
  end
  task automatic send(input logic [111:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in <= d[i];
      repeat (4) @(posedge clk);
      shift_clk <= 1;
      repeat (4) @(posedge clk);
      shift_clk <= 0;
    end
    serial_data_in <= ~d[0];
    repeat (8) @(posedge clk);
  endtask
endmodule // led_host_model

/* bench/led_serial_latch_test.sv */
// self-checking bench for the led serial latch port
// assumes the host model and the checker file are compiled first
`timescale 1ns/100ps
module led_serial_latch_test;
  reg clk = 0, rst = 1, mode_sel = 0, latch_strobe = 0, blank = 0, overtemp_flag = 0;
  reg  [15:0] open_led_detect = 16'h0000;
  wire shift_clk, serial_data_in, serial_data_out, error_out_n_o, error_out_n_oe;
  wire [15:0] chan_on, onoff_data;
  wire [111:0] brightness_correction;
  int num_errors = 0, compares = 0;
  logic [111:0] pat = {8{14'h2b5d}};
  led_host_model host (.clk, .shift_clk, .serial_data_in);
  led_serial_latch dut (.clk, .rst, .shift_clk, .serial_data_in, .mode_sel, .latch_strobe,
    .blank, .open_led_detect, .overtemp_flag, .serial_data_out, .error_out_n_o,
    .error_out_n_oe, .chan_on, .onoff_data, .brightness_correction);
  initial forever #5 clk = ~clk;
  task check(input string n, input logic [111:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task latch;
    latch_strobe <= 1;
    repeat (6) @(posedge clk);
    latch_strobe <= 0;
    repeat (6) @(posedge clk);
  endtask
  task t_onoff;
    host.send(16'ha5c3, 16);
    check("onoff_held", onoff_data, 0);
    check("serial_data_out", serial_data_out, 1);
    latch;
    check("onoff", onoff_data, 16'ha5c3);
    check("chan_on", chan_on, 16'ha5c3);
    blank <= 1;
    repeat (5) @(posedge clk);
    check("blank", chan_on, 0);
    blank <= 0;
  endtask
  task t_corr;
    mode_sel <= 1;
    repeat (6) @(posedge clk);
    host.send(pat, 112);
    check("corr_held", brightness_correction, 0);
    check("serial_data_out_corr", serial_data_out, pat[111]);
    host.send(0, 16);
    check("serial_data_out_len", serial_data_out, pat[95]);
    latch_strobe <= 1;
    repeat (6) @(posedge clk);
    check("corr_open", brightness_correction, {pat[95:0], 16'h0000});
    latch_strobe <= 0;
    repeat (6) @(posedge clk);
    check("corr", brightness_correction, {pat[95:0], 16'h0000});
    check("onoff_kept", onoff_data, 16'ha5c3);
    mode_sel <= 0;
    latch;
    check("corr_mode", brightness_correction, {pat[95:0], 16'h0000});
  endtask
  task t_err;
    for (int i = 0; i < 3; i++) begin
      overtemp_flag <= (i == 1);
      open_led_detect <= (i == 2) ? 16'h0100 : 16'h0000;
      repeat (5) @(posedge clk);
      check("err_oe", error_out_n_oe, i > 0);
      check("err_o", error_out_n_o, 0);
    end
    overtemp_flag <= 0;
    open_led_detect <= 16'h0000;
    repeat (5) @(posedge clk);
    check("err_clear", error_out_n_oe, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_onoff;
    t_corr;
    t_err;
    give_verdict;
  end
endmodule // led_serial_latch_test
bind led_serial_latch led_serial_latch_properties props (.clk, .rst, .shift_clk, .mode_sel,
  .latch_strobe, .blank, .overtemp_flag, .serial_data_out, .error_out_n_oe,
  .open_led_detect, .chan_on, .onoff_data, .brightness_correction);
